// File: src/dtc_timer_top.sv
// Dual 8-bit timer/counter with prescalers, output pin and input pin.
// Assumes an Avalon-MM master on clk_sys and an asynchronous input pin.
//
// Overview of operation
// - Two 8-bit counters, 6-bit prescalers, clock/4.
// - Single-pass stops at end; continuous reloads.
// - Load bit reloads now; else at end.
// - Prescaler registers are write-only, read zero.
// - Interval equals tick period times prescaler times count.
// - Zero means 64 prescale or 256 count.
// - External clock bypasses divider, counts input edges.
// - Output pin follows timer a, b or clock.
// - Load bit sets pin high; toggles at end.
// - Clock source puts internal clock divided by two on pin.
// - Port writes reach pin six only with output off; reads show it.
// - Input pin has four modes for timer b.
// - Trigger synchronised, start three to four clocks later.
// - Every input falling edge raises edge request.
// - External clock: request on every nth edge.
// - Gate mode counts only while input high.
// - Non-retriggerable starts on first edge after enable.
// - Single-pass trigger clears enable at end.
// - Retriggerable restarts on each edge; timeout otherwise.
`timescale 1ns/1ps
module dtc_timer_top
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port pins
  input wire logic timer_input_pin,
  output logic p3_6_out,
  // Request pulses
  output logic input_edge_request,
  output logic timer_a_request,
  output logic timer_b_request
);
  import dtc_pkg::*;

  logic ack_r;
  logic acc;
  logic wr_go;
  logic rd_cap;
  logic [7:0] wdat;
  logic [7:0] ctrl_r;
  logic [7:0] port_r;
  logic [31:0] readdata_r;
  logic [7:0] rd_val;
  logic [1:0] div_r;
  logic tick;
  logic tin_s1_r;
  logic tin_s2_r;
  logic tin_s3_r;
  logic tin_lvl_r;
  logic tin_fall;
  logic edge_req_r;
  logic p36_r;
  dtc_tout_t tout_mode;
  dtc_tin_t tin_mode;
  logic [1:0] ld_wr;
  logic [1:0] en_w;
  logic [1:0] eoc_w;
  logic [1:0] tog_w;
  logic [1:0] req_w;
  logic [8:0] cntf_w [0:1];
  logic [8:0] vfull_w [0:1];
  logic [6:0] psc_w [0:1];
  logic ext_b;

  // Bus handshake: every access waits exactly one cycle.
  assign acc = avs_read | avs_write;
  assign avs_waitrequest = acc & ~ack_r;
  assign wr_go = avs_write & ack_r & avs_byteenable[0];
  assign rd_cap = avs_read & ~ack_r;
  assign wdat = avs_writedata[7:0];
  assign avs_readdata = readdata_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ack_r <= 1'b0;
    else
      ack_r <= acc & ~ack_r;
  end

  assign tout_mode = dtc_tout_t'(ctrl_r[DTC_CTRL_TOUT_LSB +: 2]);
  assign tin_mode = dtc_tin_t'(ctrl_r[DTC_CTRL_TIN_LSB +: 2]);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_r <= DTC_CTRL_RST;
    else if (wr_go && avs_address == DTC_OFF_CTRL)
      ctrl_r <= wdat;
  end

  // The port latch keeps bit six, but the pin ignores it under timer use.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      port_r <= DTC_PORT_RST;
    else if (wr_go && avs_address == DTC_OFF_PORT)
      port_r <= wdat;
  end

  always_comb
  begin
    rd_val = 8'h00;
    unique case (avs_address)
      DTC_OFF_CTRL:
        rd_val = {ctrl_r[7:4], en_w[1], 1'b0, en_w[0], 1'b0};
      DTC_OFF_CNT_A:
        rd_val = cntf_w[0][7:0];
      DTC_OFF_CNT_B:
        rd_val = cntf_w[1][7:0];
      DTC_OFF_PORT:
        rd_val = {port_r[7], p36_r, port_r[5:2], tin_lvl_r, port_r[0]};
      default:
        rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      readdata_r <= 32'h0000_0000;
    else if (rd_cap)
      readdata_r <= {24'h00_0000, rd_val};
  end

  // Internal clock divided by four.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end
  assign tick = (div_r == DTC_DIV_LAST);

  // Three-stage input synchroniser; a level counts once stages agree.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tin_s1_r <= 1'b1;
      tin_s2_r <= 1'b1;
      tin_s3_r <= 1'b1;
      tin_lvl_r <= 1'b1;
    end
    else
    begin
      tin_s1_r <= timer_input_pin;
      tin_s2_r <= tin_s1_r;
      tin_s3_r <= tin_s2_r;
      if (tin_s2_r == tin_s3_r)
        tin_lvl_r <= tin_s3_r;
    end
  end
  assign tin_fall = (tin_s2_r == tin_s3_r) & ~tin_s3_r & tin_lvl_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      edge_req_r <= 1'b0;
    else
      edge_req_r <= tin_fall;
  end
  assign input_edge_request = edge_req_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_tmr
      localparam logic [4:0] CNT_OFF = gi ? DTC_OFF_CNT_B : DTC_OFF_CNT_A;
      localparam logic [4:0] PRE_OFF = gi ? DTC_OFF_PRE_B : DTC_OFF_PRE_A;
      localparam int LD_BIT = DTC_CTRL_LOAD_A + gi * DTC_CTRL_STRIDE;
      localparam int EN_BIT = DTC_CTRL_EN_A + gi * DTC_CTRL_STRIDE;
      logic [7:0] reload_r;
      logic [7:0] pre_r;
      logic en_r;
      logic armed_r;
      logic [6:0] psc_r;
      logic [8:0] cnt_r;
      logic tog_r;
      logic req_r;
      logic [6:0] pfull;
      logic [8:0] vfull;
      logic cont;
      logic src_tick;
      logic trig;
      logic need_arm;
      logic active;
      logic pulse;
      logic eoc;
      logic ctrl_wr;

      assign ctrl_wr = wr_go && avs_address == DTC_OFF_CTRL;
      assign ld_wr[gi] = ctrl_wr & wdat[LD_BIT];
      assign pfull = {pre_r[7:DTC_PRE_LSB] == 6'h00,
                      pre_r[7:DTC_PRE_LSB]};
      assign vfull = {reload_r == 8'h00, reload_r};
      assign cont = pre_r[DTC_PRE_CONT];

      if (gi == 0)
      begin : g_src_a
        assign src_tick = tick;
        assign trig = 1'b0;
        assign need_arm = 1'b0;
      end
      else
      begin : g_src_b
        always_comb
        begin
          src_tick = tick;
          trig = 1'b0;
          need_arm = 1'b0;
          if (ext_b)
          begin
            unique case (tin_mode)
              DTC_TIN_EXT:
                src_tick = tin_fall;
              DTC_TIN_GATE:
                src_tick = tick & tin_lvl_r;
              DTC_TIN_NRTRIG:
              begin
                need_arm = 1'b1;
                trig = en_r & ~armed_r & tin_fall;
              end
              DTC_TIN_RTRIG:
              begin
                need_arm = 1'b1;
                trig = en_r & tin_fall;
              end
            endcase
          end
        end
      end

      assign active = en_r & (~need_arm | armed_r);
      assign pulse = active & src_tick & (psc_r == 7'h01);
      assign eoc = pulse & (cnt_r == 9'h001);

      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          reload_r <= DTC_RELOAD_RST;
          pre_r <= DTC_PRE_RST;
        end
        else
        begin
          if (wr_go && avs_address == CNT_OFF)
            reload_r <= wdat;
          if (wr_go && avs_address == PRE_OFF)
            pre_r <= wdat;
        end
      end

      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          en_r <= 1'b0;
        else if (ctrl_wr)
          en_r <= wdat[EN_BIT];
        else if (eoc && !cont)
          en_r <= 1'b0;
      end

      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          armed_r <= 1'b0;
        else if (trig)
          armed_r <= 1'b1;
        else if (!en_r || (eoc && !cont))
          armed_r <= 1'b0;
      end

      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          psc_r <= DTC_PSC_RST;
          cnt_r <= DTC_CNT_RST;
        end
        else if (ld_wr[gi] || trig)
        begin
          psc_r <= pfull;
          cnt_r <= vfull;
        end
        else if (active && src_tick)
        begin
          psc_r <= (psc_r == 7'h01) ? pfull : psc_r - 7'h01;
          if (pulse)
            cnt_r <= eoc ? vfull : cnt_r - 9'h001;
        end
      end

      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          tog_r <= 1'b1;
        else if (ld_wr[gi])
          tog_r <= 1'b1;
        else if (eoc)
          tog_r <= ~tog_r;
      end

      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          req_r <= 1'b0;
        else
          req_r <= eoc;
      end

      assign en_w[gi] = en_r;
      assign eoc_w[gi] = eoc;
      assign tog_w[gi] = tog_r;
      assign req_w[gi] = req_r;
      assign cntf_w[gi] = cnt_r;
      assign vfull_w[gi] = vfull;
      assign psc_w[gi] = psc_r;
    end
  endgenerate

  assign ext_b = ~g_tmr[1].pre_r[DTC_PRE_INT];
  assign timer_a_request = req_w[0];
  assign timer_b_request = req_w[1];

  // Output pin source select.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      p36_r <= 1'b0;
    else
    begin
      unique case (tout_mode)
        DTC_TOUT_OFF:
          p36_r <= port_r[DTC_PORT_TOUT];
        DTC_TOUT_A:
          p36_r <= tog_w[0];
        DTC_TOUT_B:
          p36_r <= tog_w[1];
        DTC_TOUT_CLK:
          p36_r <= div_r[0];
      endcase
    end
  end
  assign p3_6_out = p36_r;

  default clocking dtc_cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  AST_DIV_TICK:
    assert property (tick |=> !tick [*3] ##1 tick)
    else $error("Prescaler tick is not every fourth cycle.");
  AST_SINGLE_STOP:
    assert property (eoc_w[0] && !g_tmr[0].cont && !g_tmr[0].ctrl_wr
                     |=> !en_w[0])
    else $error("Single-pass timer a kept running after end.");
  AST_LOAD_NOW:
    assert property (ld_wr[0] |=> cntf_w[0] == $past(vfull_w[0]))
    else $error("Load bit did not reload timer a at once.");
  AST_PRE_READ:
    assert property (rd_cap && (avs_address == DTC_OFF_PRE_A
                     || avs_address == DTC_OFF_PRE_B)
                     |=> avs_readdata == 32'h0000_0000)
    else $error("Prescaler register returned data.");
  AST_ZERO_MAX:
    assert property (eoc_w[0] && !ld_wr[0] && g_tmr[0].reload_r == 8'h00
                     |=> cntf_w[0] == 9'h100)
    else $error("Zero count did not mean 256.");
  AST_EXT_HOLD:
    assert property (ext_b && tin_mode == DTC_TIN_EXT && !tin_fall
                     && !ld_wr[1] |=> $stable(psc_w[1]))
    else $error("External clock mode counted without an edge.");
  AST_GATE_HOLD:
    assert property (ext_b && tin_mode == DTC_TIN_GATE && !tin_lvl_r
                     && !ld_wr[1] |=> $stable(psc_w[1]))
    else $error("Gate mode counted while the input was low.");
  AST_TOUT_LOAD:
    assert property (ld_wr[0] |=> tog_w[0])
    else $error("Load bit did not force the toggle high.");
  AST_TOUT_TOG:
    assert property (eoc_w[1] && !ld_wr[1] |=> tog_w[1] != $past(tog_w[1]))
    else $error("Toggle did not change at end of count.");
  AST_PIN_SRC:
    assert property (tout_mode == DTC_TOUT_A |=> p3_6_out == $past(tog_w[0]))
    else $error("Pin does not follow timer a.");
  AST_PORT_READ:
    assert property (rd_cap && avs_address == DTC_OFF_PORT
                     |=> avs_readdata[DTC_PORT_TOUT] == $past(p3_6_out))
    else $error("Port read does not show the pin level.");
  AST_EDGE_REQ:
    assert property (tin_fall |=> input_edge_request ##1 !input_edge_request)
    else $error("Input edge request missing or too long.");
  AST_EOC_REQ:
    assert property (eoc_w[1] |=> timer_b_request)
    else $error("Timer b request missing at end of count.");

  COV_A_EOC: cover property (eoc_w[0] && g_tmr[0].cont);
  COV_RTRIG: cover property (g_tmr[1].trig && tin_mode == DTC_TIN_RTRIG);
  COV_B_REQ: cover property (timer_b_request && ext_b);
endmodule

// File: common/dtc_pkg.sv
// Constants and types for the dual down-counting timer block.
// Assumes an Avalon-MM master with 8-bit registers in byte lane 0.
package dtc_pkg;

  // Register byte offsets.
  localparam logic [4:0] DTC_OFF_CTRL = 5'h00;
  localparam logic [4:0] DTC_OFF_CNT_A = 5'h04;
  localparam logic [4:0] DTC_OFF_PRE_A = 5'h08;
  localparam logic [4:0] DTC_OFF_CNT_B = 5'h0C;
  localparam logic [4:0] DTC_OFF_PRE_B = 5'h10;
  localparam logic [4:0] DTC_OFF_PORT = 5'h14;

  // Control register fields; timer b fields sit one stride above a.
  localparam int DTC_CTRL_LOAD_A = 0;
  localparam int DTC_CTRL_EN_A = 1;
  localparam int DTC_CTRL_STRIDE = 2;
  localparam int DTC_CTRL_TOUT_LSB = 4;
  localparam int DTC_CTRL_TIN_LSB = 6;

  // Prescaler register fields.
  localparam int DTC_PRE_CONT = 0;
  localparam int DTC_PRE_INT = 1;
  localparam int DTC_PRE_LSB = 2;

  // Port 3 bit positions.
  localparam int DTC_PORT_TOUT = 6;
  localparam int DTC_PORT_TIN = 1;

  // Values after reset.
  localparam logic [7:0] DTC_CTRL_RST = 8'h00;
  localparam logic [7:0] DTC_PRE_RST = 8'h00;
  localparam logic [7:0] DTC_RELOAD_RST = 8'h00;
  localparam logic [7:0] DTC_PORT_RST = 8'h00;
  localparam logic [6:0] DTC_PSC_RST = 7'h40;
  localparam logic [8:0] DTC_CNT_RST = 9'h100;

  // Internal clock divided by four gives the prescaler input tick.
  localparam logic [1:0] DTC_DIV_LAST = 2'h3;

  typedef enum logic [1:0] {
    DTC_TOUT_OFF,
    DTC_TOUT_A,
    DTC_TOUT_B,
    DTC_TOUT_CLK
  } dtc_tout_t;

  typedef enum logic [1:0] {
    DTC_TIN_EXT,
    DTC_TIN_GATE,
    DTC_TIN_NRTRIG,
    DTC_TIN_RTRIG
  } dtc_tin_t;

endpackage

// File: sim/dtc_pin_model.sv
// Event source on the input pin and load on the output pin.
// Assumes the bench calls its tasks on clk_sys; the pin idles high.
`timescale 1ns/1ps
module dtc_pin_model (
  // Clock
  input wire logic clk_sys,
  // Pins
  input wire logic p3_6_out,
  output logic timer_input_pin
);
  int rises;
  initial timer_input_pin = 1'b1;
  always @(posedge p3_6_out) rises++;
  task automatic level(input logic l);
    @(posedge clk_sys);
    timer_input_pin <= l;
  endtask
  task automatic fall(input int n, input int h);
    repeat (n)
    begin
      level(1'b0);
      repeat (h - 1) @(posedge clk_sys);
      level(1'b1);
      repeat (h - 1) @(posedge clk_sys);
    end
  endtask
endmodule

// File: sim/dtc_timer_top_tb.sv
// Self-checking bench for the dual timer block.
// Assumes the package and the pin model are compiled first.
`timescale 1ns/1ps
module dtc_timer_top_tb;
  import dtc_pkg::*;
  logic clk_sys, arst_n, avs_read, avs_write;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, timer_input_pin, p3_6_out;
  logic input_edge_request, timer_a_request, timer_b_request;
  int fails, comparisons, cyc, na, nb, ne, p, v, w, e, b0, r0;
  time t;
  dtc_timer_top uut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .timer_input_pin(timer_input_pin),
    .p3_6_out(p3_6_out),
    .input_edge_request(input_edge_request),
    .timer_a_request(timer_a_request),
    .timer_b_request(timer_b_request)
  );
  dtc_pin_model mdl (
    .clk_sys(clk_sys),
    .p3_6_out(p3_6_out),
    .timer_input_pin(timer_input_pin)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    na += int'(timer_a_request === 1'b1);
    nb += int'(timer_b_request === 1'b1);
    ne += int'(input_edge_request === 1'b1);
    if (cyc == 20000)
    begin
      fails++;
      final_report();
    end
  end
  function automatic int iv(input int p, input int v);
    return 4 * (p == 0 ? 64 : p) * (v == 0 ? 256 : v);
  endfunction
  task automatic bus(input bit wr, input logic [4:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic chk_in(input string n, input int lo, input int hi,
                        input int g);
    comparisons++;
    if (g < lo || g > hi)
    begin
      fails++;
      $display("unexpected %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic wreq(input bit s);
    do @(posedge clk_sys);
    while ((s ? timer_b_request : timer_a_request) !== 1'b1);
  endtask
  task automatic nap(input int c);
    repeat (c) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    void'($urandom(5));
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    bus(0, DTC_OFF_CTRL, 8'h00);
    chk("ctrl", {24'h000000, DTC_CTRL_RST}, rdat);
    bus(0, DTC_OFF_CNT_A, 8'h00);
    chk("count", 32'h00000000, rdat);
    bus(1, DTC_OFF_PRE_A, 8'hFD);
    bus(0, DTC_OFF_PRE_A, 8'h00);
    chk("prescaler", 32'h00000000, rdat);
    bus(0, 5'h18, 8'h00);
    chk("unmapped", 32'h00000000, rdat);
    for (int i = 0; i < 4; i++)
    begin
      p = (i == 2) ? 0 : 1 + $urandom % 3;
      v = 2 + $urandom % 3;
      w = (i == 3) ? 0 : 1 + $urandom % 4;
      e = iv(p, v);
      bus(1, DTC_OFF_PRE_A, {p[5:0], 2'h1});
      bus(1, DTC_OFF_CNT_A, v[7:0]);
      bus(1, DTC_OFF_CTRL, 8'h13);
      t = $time;
      bus(1, DTC_OFF_CNT_A, w[7:0]);
      chk("pin load", 32'h1, {31'h0, p3_6_out});
      wreq(0);
      chk_in("first", e - 3, e + 3, int'(($time - t) / 20));
      t = $time;
      e = iv(p, w);
      @(negedge clk_sys);
      chk("pin end", 32'h0, {31'h0, p3_6_out});
      wreq(0);
      chk_in("next", e, e, int'(($time - t) / 20));
    end
    bus(1, DTC_OFF_PRE_A, 8'h04);
    bus(1, DTC_OFF_CNT_A, 8'h03);
    bus(1, DTC_OFF_CTRL, 8'h13);
    wreq(0);
    nap(0);
    r0 = na;
    nap(40);
    chk("single", r0, na);
    bus(0, DTC_OFF_CTRL, 8'h00);
    chk("ctrl end", 32'h10, rdat);
    bus(1, DTC_OFF_PORT, 8'h40);
    bus(0, DTC_OFF_PORT, 8'h00);
    chk("port bit", 32'h0, {31'h0, rdat[DTC_PORT_TOUT]});
    chk("pin kept", 32'h0, {31'h0, p3_6_out});
    bus(1, DTC_OFF_CTRL, 8'h30);
    r0 = mdl.rises;
    nap(20);
    chk_in("clock out", 9, 11, mdl.rises - r0);
    bus(1, DTC_OFF_PRE_B, 8'h09);
    bus(1, DTC_OFF_CNT_B, 8'h03);
    bus(1, DTC_OFF_CTRL, 8'h2C);
    b0 = nb;
    r0 = ne;
    mdl.fall(5, 3);
    nap(10);
    chk("ext short", b0, nb);
    mdl.fall(1, 3);
    nap(10);
    chk("ext nth", b0 + 1, nb);
    chk("pin b", 32'h0, {31'h0, p3_6_out});
    chk("edges", r0 + 6, ne);
    mdl.fall(6, 3);
    nap(10);
    chk("ext every", b0 + 2, nb);
    bus(1, DTC_OFF_CTRL, 8'h00);
    bus(1, DTC_OFF_PRE_B, 8'h04);
    bus(1, DTC_OFF_CNT_B, 8'h04);
    r0 = ne;
    mdl.level(1'b0);
    nap(8);
    chk("edge off", r0 + 1, ne);
    bus(1, DTC_OFF_CTRL, 8'h4C);
    b0 = nb;
    nap(60);
    chk("gate low", b0, nb);
    mdl.level(1'b1);
    nap(30);
    chk("gate high", b0 + 1, nb);
    bus(1, DTC_OFF_CTRL, 8'h88);
    b0 = nb;
    mdl.fall(6, 5);
    nap(2);
    chk("no retrig", b0 + 1, nb);
    bus(0, DTC_OFF_CTRL, 8'h00);
    chk("ctrl trig", 32'h80, rdat);
    mdl.fall(3, 5);
    nap(30);
    chk("ignored", b0 + 1, nb);
    bus(1, DTC_OFF_CTRL, 8'hC8);
    b0 = nb;
    mdl.fall(6, 5);
    t = $time;
    nap(0);
    chk("retrig", b0, nb);
    wreq(1);
    chk_in("timeout", 6, 14, int'(($time - t) / 20));
    bus(1, DTC_OFF_CTRL, 8'h00);
    final_report();
  end
endmodule
